/* File: tcpwm_pkg.sv */
package tcpwm_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NCH = 3;
  localparam int ADDR_W = 8;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PERIOD_ONE = 8'h04;
  localparam logic [7:0] OFF_PERIOD_TWO = 8'h08;
  localparam logic [7:0] OFF_TIMER_ONE = 8'h0C;
  localparam logic [7:0] OFF_TIMER_TWO = 8'h10;
  localparam logic [7:0] OFF_DUTY_HIGH [NCH] = '{8'h14, 8'h1C, 8'h24};
  localparam logic [7:0] OFF_DUTY_LOW [NCH] = '{8'h18, 8'h20, 8'h28};
  localparam logic [7:0] OFF_INT_STATUS = 8'h2C;
  localparam logic [7:0] OFF_INT_CLEAR = 8'h30;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h34;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_RUN_ONE = 0;
  localparam int CTRL_RUN_TWO = 1;
  localparam int CTRL_OUT_EN_LSB = 2;
  localparam int DUTYL_TBSEL = 5;
  localparam int DUTYL_FRAC_LSB = 6;
  localparam int INT_ROLL_ONE = 0;
  localparam int INT_ROLL_TWO = 1;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [4:0] RST_CTRL = 5'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_DUTY_HIGH = 8'h00;
  localparam logic [1:0] RST_DUTY_FRAC = 2'h0;
  localparam logic [1:0] RST_INT = 2'h0;
  localparam logic [1:0] RST_PHASE = 2'h0;
  localparam logic [7:0] RST_TIMER = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ------------------------------------------------------------
  // timing: one timer increment takes four oscillator periods
  // ------------------------------------------------------------
  localparam int OSC_PERIODS_PER_TICK = 4;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PERIODS_PER_TICK - 1);

endpackage

/* File: tcpwm_unit.sv */
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - output one always timed by timer one
// - output two timer chosen by its bit5
// - output three timer chosen by its bit5
// - timers never cascade into sixteen bits
// - duty is high byte plus bits 7:6
// - high for duty oscillator periods per period
// - zero duty keeps output low
// - duty high equals period: short low
// - full high only when duty exceeds period
// - writes held, copied at rollover, output high unless duty is zero
// - duty reads return active latch value
// - match clears timer, raises flag, new period
// - rollover flags sticky until software clears
module tcpwm_unit (
  input wire logic core_clk, // oscillator clock
  input wire logic reset_n, // async reset
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic pulse_out_one, // pulse output one
  output logic pulse_out_two, // pulse output two
  output logic pulse_out_three, // pulse output three
  output logic irq // interrupt level
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // position {timer,phase} counts oscillator periods from period start
  function automatic logic duty_active(
    input logic [7:0] tmr,
    input logic [1:0] phase,
    input logic [7:0] per,
    input logic [7:0] dh,
    input logic [1:0] df
  );
    logic res;
    res = 1'b0;
    if (dh > per) begin
      res = 1'b1;
    end else begin
      // also gives zero duty and the short low at dh == per
      res = ({tmr, phase} < {dh, df});
    end
    return res;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == tcpwm_pkg::OFF_CTRL || a == tcpwm_pkg::OFF_PERIOD_ONE ||
        a == tcpwm_pkg::OFF_PERIOD_TWO || a == tcpwm_pkg::OFF_TIMER_ONE ||
        a == tcpwm_pkg::OFF_TIMER_TWO || a == tcpwm_pkg::OFF_INT_STATUS ||
        a == tcpwm_pkg::OFF_INT_CLEAR || a == tcpwm_pkg::OFF_INT_ENABLE) begin
      hit = 1'b1;
    end
    for (int i = 0; i < tcpwm_pkg::NCH; i++) begin
      if (a == tcpwm_pkg::OFF_DUTY_HIGH[i] || a == tcpwm_pkg::OFF_DUTY_LOW[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [4:0] ctrl_ff;
  logic [4:0] nxt_ctrl;
  logic [7:0] period_reg_one_ff;
  logic [7:0] nxt_period_reg_one;
  logic [7:0] period_reg_two_ff;
  logic [7:0] nxt_period_reg_two;
  logic [1:0] phase_ff;
  logic [1:0] nxt_phase;
  logic [7:0] timer_one_ff;
  logic [7:0] nxt_timer_one;
  logic [7:0] timer_two_ff;
  logic [7:0] nxt_timer_two;
  logic [7:0] dh_hold_ff [tcpwm_pkg::NCH];
  logic [7:0] nxt_dh_hold [tcpwm_pkg::NCH];
  logic [1:0] df_hold_ff [tcpwm_pkg::NCH];
  logic [1:0] nxt_df_hold [tcpwm_pkg::NCH];
  logic [7:0] dh_act_ff [tcpwm_pkg::NCH];
  logic [7:0] nxt_dh_act [tcpwm_pkg::NCH];
  logic [1:0] df_act_ff [tcpwm_pkg::NCH];
  logic [1:0] nxt_df_act [tcpwm_pkg::NCH];
  logic [tcpwm_pkg::NCH-1:0] tbsel_ff;
  logic [tcpwm_pkg::NCH-1:0] nxt_tbsel;
  logic [tcpwm_pkg::NCH-1:0] out_ff;
  logic [tcpwm_pkg::NCH-1:0] nxt_out;
  logic [1:0] int_status_ff;
  logic [1:0] nxt_int_status;
  logic [1:0] int_enable_ff;
  logic [1:0] nxt_int_enable;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic setup_phase;
  logic access_phase;
  logic wr_en;
  logic [7:0] wbyte;
  logic [31:0] rd_mux;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_en = access_phase & pwrite & addr_mapped(paddr);
  // no register is wider than one byte; pwdata[31:8] is ignored
  assign wbyte = pwdata[7:0];

  // zero wait state; read data was latched in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access_phase & ~addr_mapped(paddr);
  assign prdata = prdata_ff;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      tcpwm_pkg::OFF_CTRL: rd_mux = {27'h000_0000, ctrl_ff};
      tcpwm_pkg::OFF_PERIOD_ONE: rd_mux = {24'h00_0000, period_reg_one_ff};
      tcpwm_pkg::OFF_PERIOD_TWO: rd_mux = {24'h00_0000, period_reg_two_ff};
      tcpwm_pkg::OFF_TIMER_ONE: rd_mux = {24'h00_0000, timer_one_ff};
      tcpwm_pkg::OFF_TIMER_TWO: rd_mux = {24'h00_0000, timer_two_ff};
      tcpwm_pkg::OFF_INT_STATUS: rd_mux = {30'h0000_0000, int_status_ff};
      tcpwm_pkg::OFF_INT_ENABLE: rd_mux = {30'h0000_0000, int_enable_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
    for (int i = 0; i < tcpwm_pkg::NCH; i++) begin
      if (paddr == tcpwm_pkg::OFF_DUTY_HIGH[i]) begin
        rd_mux = {24'h00_0000, dh_act_ff[i]};
      end
      if (paddr == tcpwm_pkg::OFF_DUTY_LOW[i]) begin
        rd_mux = {24'h00_0000, df_act_ff[i], tbsel_ff[i], 5'h00};
      end
    end
  end

  // ------------------------------------------------------------
  // write strobes
  // ------------------------------------------------------------
  logic wr_ctrl;
  logic wr_period_one;
  logic wr_period_two;
  logic wr_int_clear;
  logic wr_int_enable;
  logic [tcpwm_pkg::NCH-1:0] wr_duty_high;
  logic [tcpwm_pkg::NCH-1:0] wr_duty_low;

  assign wr_ctrl = wr_en & (paddr == tcpwm_pkg::OFF_CTRL);
  assign wr_period_one = wr_en & (paddr == tcpwm_pkg::OFF_PERIOD_ONE);
  assign wr_period_two = wr_en & (paddr == tcpwm_pkg::OFF_PERIOD_TWO);
  assign wr_int_clear = wr_en & (paddr == tcpwm_pkg::OFF_INT_CLEAR);
  assign wr_int_enable = wr_en & (paddr == tcpwm_pkg::OFF_INT_ENABLE);

  always_comb begin
    for (int i = 0; i < tcpwm_pkg::NCH; i++) begin
      wr_duty_high[i] = wr_en & (paddr == tcpwm_pkg::OFF_DUTY_HIGH[i]);
      wr_duty_low[i] = wr_en & (paddr == tcpwm_pkg::OFF_DUTY_LOW[i]);
    end
  end

  // ------------------------------------------------------------
  // time bases
  // ------------------------------------------------------------
  logic run_one;
  logic run_two;
  logic tick;
  logic roll_one;
  logic roll_two;

  assign run_one = ctrl_ff[tcpwm_pkg::CTRL_RUN_ONE];
  assign run_two = ctrl_ff[tcpwm_pkg::CTRL_RUN_TWO];
  assign tick = (phase_ff == tcpwm_pkg::PHASE_LAST);
  // the match is caught on the increment that would leave it
  assign roll_one = run_one & tick & (timer_one_ff == period_reg_one_ff);
  assign roll_two = run_two & tick & (timer_two_ff == period_reg_two_ff);

  always_comb begin
    nxt_phase = phase_ff + 2'h1;
    nxt_timer_one = timer_one_ff;
    nxt_timer_two = timer_two_ff;
    // each timer is its own 8-bit base; no carry ever links them
    if (run_one && tick) begin
      nxt_timer_one = roll_one ? 8'h00 : timer_one_ff + 8'h01;
    end
    if (run_two && tick) begin
      nxt_timer_two = roll_two ? 8'h00 : timer_two_ff + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // control and interrupt registers
  // ------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_period_reg_one = period_reg_one_ff;
    nxt_period_reg_two = period_reg_two_ff;
    nxt_int_enable = int_enable_ff;
    nxt_prdata = prdata_ff;
    if (setup_phase && !pwrite) begin
      nxt_prdata = rd_mux;
    end
    // timer and status addresses have no write path: such writes drop
    if (wr_ctrl) begin
      nxt_ctrl = wbyte[4:0];
    end
    if (wr_period_one) begin
      nxt_period_reg_one = wbyte;
    end
    if (wr_period_two) begin
      nxt_period_reg_two = wbyte;
    end
    if (wr_int_enable) begin
      nxt_int_enable = wbyte[1:0];
    end
  end

  // a rollover in the clearing cycle survives: set wins over clear
  always_comb begin
    nxt_int_status = int_status_ff;
    if (wr_int_clear) begin
      nxt_int_status = int_status_ff & ~wbyte[1:0];
    end
    nxt_int_status[tcpwm_pkg::INT_ROLL_ONE] =
      nxt_int_status[tcpwm_pkg::INT_ROLL_ONE] | roll_one;
    nxt_int_status[tcpwm_pkg::INT_ROLL_TWO] =
      nxt_int_status[tcpwm_pkg::INT_ROLL_TWO] | roll_two;
  end

  assign irq = |(int_status_ff & int_enable_ff);

  // ------------------------------------------------------------
  // duty channels
  // ------------------------------------------------------------
  // software must not read-modify-write duty registers: reads show the
  // active copy, so a pending value is lost that way
  logic [tcpwm_pkg::NCH-1:0] ch_roll;
  logic [tcpwm_pkg::NCH-1:0] ch_run;
  logic [7:0] ch_nxt_timer [tcpwm_pkg::NCH];
  logic [7:0] ch_period [tcpwm_pkg::NCH];

  always_comb begin
    for (int i = 0; i < tcpwm_pkg::NCH; i++) begin
      // channel zero has no select bit; its tbsel stays zero
      if (tbsel_ff[i]) begin
        ch_roll[i] = roll_two;
        ch_run[i] = run_two;
        ch_nxt_timer[i] = nxt_timer_two;
        ch_period[i] = period_reg_two_ff;
      end else begin
        ch_roll[i] = roll_one;
        ch_run[i] = run_one;
        ch_nxt_timer[i] = nxt_timer_one;
        ch_period[i] = period_reg_one_ff;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < tcpwm_pkg::NCH; i++) begin
      nxt_dh_hold[i] = dh_hold_ff[i];
      nxt_df_hold[i] = df_hold_ff[i];
      nxt_tbsel[i] = tbsel_ff[i];
      nxt_dh_act[i] = dh_act_ff[i];
      nxt_df_act[i] = df_act_ff[i];
      if (wr_duty_high[i]) begin
        nxt_dh_hold[i] = wbyte;
      end
      if (wr_duty_low[i]) begin
        nxt_df_hold[i] = wbyte[tcpwm_pkg::DUTYL_FRAC_LSB +: 2];
        if (i != 0) begin
          nxt_tbsel[i] = wbyte[tcpwm_pkg::DUTYL_TBSEL];
        end
      end
      // holding copy goes live at the start of each period
      if (ch_roll[i]) begin
        nxt_dh_act[i] = dh_hold_ff[i];
        nxt_df_act[i] = df_hold_ff[i];
      end
      // the output is computed for the counter position of the next
      // cycle, so the pin tracks the timer without a cycle of lag;
      // at rollover that position is zero, which drives the pin high for any nonzero duty
      nxt_out[i] = ctrl_ff[tcpwm_pkg::CTRL_OUT_EN_LSB + i] & ch_run[i] &
        duty_active(ch_nxt_timer[i], nxt_phase, ch_period[i],
                    nxt_dh_act[i], nxt_df_act[i]);
    end
  end

  assign pulse_out_one = out_ff[0];
  assign pulse_out_two = out_ff[1];
  assign pulse_out_three = out_ff[2];

  // ------------------------------------------------------------
  // registers: bus side
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= tcpwm_pkg::RST_CTRL;
      period_reg_one_ff <= tcpwm_pkg::RST_PERIOD;
      period_reg_two_ff <= tcpwm_pkg::RST_PERIOD;
      int_enable_ff <= tcpwm_pkg::RST_INT;
      prdata_ff <= tcpwm_pkg::RST_RDATA;
    end else begin
      ctrl_ff <= nxt_ctrl;
      period_reg_one_ff <= nxt_period_reg_one;
      period_reg_two_ff <= nxt_period_reg_two;
      int_enable_ff <= nxt_int_enable;
      prdata_ff <= nxt_prdata;
    end
  end

  // ------------------------------------------------------------
  // registers: time base
  // ------------------------------------------------------------
  // the phase runs even with both timers stopped, so a timer started
  // later still steps on the shared four-clock grid
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= tcpwm_pkg::RST_PHASE;
      timer_one_ff <= tcpwm_pkg::RST_TIMER;
      timer_two_ff <= tcpwm_pkg::RST_TIMER;
    end else begin
      phase_ff <= nxt_phase;
      timer_one_ff <= nxt_timer_one;
      timer_two_ff <= nxt_timer_two;
    end
  end

  // ------------------------------------------------------------
  // registers: interrupt flags
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_status_ff <= tcpwm_pkg::RST_INT;
    end else begin
      int_status_ff <= nxt_int_status;
    end
  end

  // ------------------------------------------------------------
  // registers: channels
  // ------------------------------------------------------------

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < tcpwm_pkg::NCH; i++) begin
        dh_hold_ff[i] <= tcpwm_pkg::RST_DUTY_HIGH;
        df_hold_ff[i] <= tcpwm_pkg::RST_DUTY_FRAC;
        dh_act_ff[i] <= tcpwm_pkg::RST_DUTY_HIGH;
        df_act_ff[i] <= tcpwm_pkg::RST_DUTY_FRAC;
      end
      tbsel_ff <= '0;
      out_ff <= '0;
    end else begin
      for (int i = 0; i < tcpwm_pkg::NCH; i++) begin
        dh_hold_ff[i] <= nxt_dh_hold[i];
        df_hold_ff[i] <= nxt_df_hold[i];
        dh_act_ff[i] <= nxt_dh_act[i];
        df_act_ff[i] <= nxt_df_act[i];
      end
      tbsel_ff <= nxt_tbsel;
      out_ff <= nxt_out;
    end
  end

endmodule

/* File: tcpwm_monitor.sv */
`timescale 1ns/1ps
module tcpwm_monitor (
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset
  input wire logic [7:0] paddr, // address
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic pulse_out_one, // pin one
  input wire logic pulse_out_two, // pin two
  input wire logic pulse_out_three, // pin three
  input wire logic irq // interrupt
);
  // ------------------------------------------------------------
  // history since reset
  // ------------------------------------------------------------
  logic ctrl_seen_ff;
  logic nxt_ctrl_seen;
  logic ena_seen_ff;
  logic nxt_ena_seen;
  logic wr_acc;
  assign wr_acc = psel & penable & pwrite;
  always_comb begin
    nxt_ctrl_seen = ctrl_seen_ff | (wr_acc & (paddr == tcpwm_pkg::OFF_CTRL));
    nxt_ena_seen = ena_seen_ff | (wr_acc & (paddr == tcpwm_pkg::OFF_INT_ENABLE)
      & (pwdata[1:0] != 2'h0));
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_seen_ff <= 1'b0;
      ena_seen_ff <= 1'b0;
    end else begin
      ctrl_seen_ff <= nxt_ctrl_seen;
      ena_seen_ff <= nxt_ena_seen;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_read_done;
    psel && penable && !pwrite ##1 !psel;
  endsequence
  a_ready_zero_wait: assert property (s_access |-> pready)
    else $error("pready low in access phase");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_err_unmapped: assert property (s_access ##0 (paddr > tcpwm_pkg::OFF_INT_ENABLE) |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped_ok: assert property (s_access ##0 (paddr <= tcpwm_pkg::OFF_INT_ENABLE
    && paddr[1:0] == 2'h0) |-> !pslverr) else $error("error on mapped address");
  a_refused_read_zero: assert property (s_access ##0 (!pwrite && pslverr) |-> prdata == '0)
    else $error("refused read not zero");
  a_rdata_hold: assert property (s_read_done |-> $stable(prdata))
    else $error("read data moved after access");
  a_irq_sticky: assert property (irq && !wr_acc |=> irq)
    else $error("irq dropped without a write");
  a_irq_needs_enable: assert property (irq |-> ena_seen_ff)
    else $error("irq without enable");
  a_quiet_release: assert property ($rose(reset_n) |-> !pulse_out_one
    && !pulse_out_two && !pulse_out_three && !irq) else $error("output high at reset release");
  a_pulse_needs_ctrl: assert property ((pulse_out_one || pulse_out_two
    || pulse_out_three) |-> ctrl_seen_ff) else $error("pulse before configuration");
endmodule

/* File: tcpwm_load.sv */
`timescale 1ns/1ps
module tcpwm_load (
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset
  input wire logic pin, // driven pulse
  output logic [11:0] hi_last, // high clocks of last period
  output logic [11:0] len_last // clocks from rise to rise
);
  logic prev_ff;
  logic [11:0] hi_ff;
  logic [11:0] len_ff;
  // measures rise to rise, so steady high or low leaves the last figures
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_ff <= 1'b0;
      hi_ff <= '0;
      len_ff <= '0;
      hi_last <= '0;
      len_last <= '0;
    end else begin
      prev_ff <= pin;
      if (pin && !prev_ff) begin
        hi_last <= hi_ff;
        len_last <= len_ff;
        hi_ff <= 12'h001;
        len_ff <= 12'h001;
      end else begin
        hi_ff <= hi_ff + {11'h000, pin};
        len_ff <= len_ff + 12'h001;
      end
    end
  end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  typedef struct {int ch; logic [7:0] dh; logic [7:0] dl; logic [11:0] hi; logic [11:0] len;}
    tcpwm_row_t;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire [2:0] pins;
  logic [11:0] ld_hi [3];
  logic [11:0] ld_len [3];
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  // period one is 3 (16 clocks), period two is 5 (24 clocks)
  tcpwm_row_t rows [6] = '{'{0, 8'h01, 8'h80, 12'h006, 12'h010},
    '{1, 8'h02, 8'h40, 12'h009, 12'h010}, '{1, 8'h02, 8'hE0, 12'h00B, 12'h018},
    '{2, 8'h05, 8'h60, 12'h015, 12'h018}, '{2, 8'h03, 8'h00, 12'h00C, 12'h010},
    '{0, 8'h03, 8'hC0, 12'h00F, 12'h010}};
  tcpwm_unit dut (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_out_one(pins[0]), .pulse_out_two(pins[1]),
    .pulse_out_three(pins[2]), .irq(irq));
  for (genvar i = 0; i < 3; i++) begin : g_load
    tcpwm_load u_load (.core_clk(core_clk), .reset_n(reset_n), .pin(pins[i]),
      .hi_last(ld_hi[i]), .len_last(ld_len[i]));
  end
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // a hang in the pready wait of the apb task ends here
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(logic [7:0] a, logic [31:0] e, string n);
    apb(1'b0, a, 32'h0000_0000);
    chk_val(n, e, rd);
  endtask
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      rdchk(tcpwm_pkg::OFF_DUTY_HIGH[c], 32'h0000_0000, "duty high at reset");
      rdchk(tcpwm_pkg::OFF_DUTY_LOW[c], 32'h0000_0000, "duty low at reset");
    end
    chk_val("pins at reset", 32'h0000_0000, {29'h0, pins});
    apb(1'b1, tcpwm_pkg::OFF_PERIOD_ONE, 32'h0000_0003);
    apb(1'b1, tcpwm_pkg::OFF_PERIOD_TWO, 32'h0000_0005);
    apb(1'b1, tcpwm_pkg::OFF_CTRL, 32'h0000_001F);
    foreach (rows[i]) begin
      apb(1'b1, tcpwm_pkg::OFF_DUTY_LOW[rows[i].ch], {24'h0, rows[i].dl});
      apb(1'b1, tcpwm_pkg::OFF_DUTY_HIGH[rows[i].ch], {24'h0, rows[i].dh});
      repeat (100) @(posedge core_clk);
      chk_val("high time", 32'(rows[i].hi), 32'(ld_hi[rows[i].ch]));
      chk_val("period", 32'(rows[i].len), 32'(ld_len[rows[i].ch]));
      rdchk(tcpwm_pkg::OFF_DUTY_HIGH[rows[i].ch], {24'h0, rows[i].dh}, "duty read");
    end
    // timer one stopped: no rollover, so the new value must stay pending
    apb(1'b1, tcpwm_pkg::OFF_CTRL, 32'h0000_001E);
    apb(1'b1, tcpwm_pkg::OFF_DUTY_HIGH[0], 32'h0000_0007);
    rdchk(tcpwm_pkg::OFF_DUTY_HIGH[0], 32'h0000_0003, "pending duty");
    apb(1'b1, tcpwm_pkg::OFF_CTRL, 32'h0000_001F);
    repeat (40) @(posedge core_clk);
    rdchk(tcpwm_pkg::OFF_DUTY_HIGH[0], 32'h0000_0007, "transferred duty");
    apb(1'b1, tcpwm_pkg::OFF_DUTY_HIGH[0], 32'h0000_0000);
    apb(1'b1, tcpwm_pkg::OFF_DUTY_LOW[0], 32'h0000_0000);
    apb(1'b1, tcpwm_pkg::OFF_DUTY_LOW[1], 32'h0000_0000);
    apb(1'b1, tcpwm_pkg::OFF_DUTY_HIGH[1], 32'h0000_0004);
    repeat (40) @(posedge core_clk);
    repeat (16) begin
      @(negedge core_clk);
      chk_val("zero duty pin", 32'h0000_0000, {31'h0, pins[0]});
      chk_val("full duty pin", 32'h0000_0001, {31'h0, pins[1]});
    end
    apb(1'b1, tcpwm_pkg::OFF_CTRL, 32'h0000_001C);
    rdchk(tcpwm_pkg::OFF_INT_STATUS, 32'h0000_0003, "both roll flags");
    rdchk(tcpwm_pkg::OFF_PERIOD_ONE, 32'h0000_0003, "period one");
    apb(1'b0, tcpwm_pkg::OFF_TIMER_ONE, 32'h0000_0000);
    chk_val("timer one in range", 32'h0000_0001, {31'h0, rd <= 32'h0000_0003});
    apb(1'b0, tcpwm_pkg::OFF_TIMER_TWO, 32'h0000_0000);
    chk_val("timer two in range", 32'h0000_0001, {31'h0, rd <= 32'h0000_0005});
    chk_val("irq masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, tcpwm_pkg::OFF_INT_ENABLE, 32'h0000_0001);
    @(negedge core_clk);
    chk_val("irq enabled", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, tcpwm_pkg::OFF_INT_CLEAR, 32'h0000_0001);
    @(negedge core_clk);
    chk_val("irq cleared", 32'h0000_0000, {31'h0, irq});
    rdchk(tcpwm_pkg::OFF_INT_STATUS, 32'h0000_0002, "flag two sticky");
    rdchk(8'h3C, 32'h0000_0000, "unmapped read");
    chk_val("unmapped error", 32'h0000_0001, {31'h0, rerr});
    apb(1'b1, tcpwm_pkg::OFF_CTRL, 32'h0000_001F);
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk_val("pins after reset", 32'h0000_0000, {29'h0, pins});
    rdchk(tcpwm_pkg::OFF_DUTY_HIGH[1], 32'h0000_0000, "duty after reset");
    end_sim();
  end
endmodule
bind tcpwm_unit tcpwm_monitor mon (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pulse_out_one(pulse_out_one),
  .pulse_out_two(pulse_out_two), .pulse_out_three(pulse_out_three), .irq(irq));
